/* logic/level_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  // The first stage feeds only the second stage.
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = d_i;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q_o = state_reg.stable;

endmodule // level_sync
`default_nettype wire

/* logic/pin_pad_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_pad_decode (
  input  wire port_pkg::pin_cfg_s cfg_i,
  output port_pkg::pad_bit_s      pad_o
);

  logic drive_data;
  logic banned;
  logic alt_sel;

  always_comb begin
    pad_o      = '0;
    banned     = cfg_i.banned[cfg_i.func];
    alt_sel    = (cfg_i.func != port_pkg::FUNC_GPIO);
    // A prohibited function forces a low data bit: P-channel then stays released, N-channel and CMOS pull low.
    drive_data = banned ? 1'b0 : (alt_sel ? cfg_i.alt : cfg_i.data);
    if (cfg_i.dir == port_pkg::DIR_OUT) begin
      case (cfg_i.drive)
        port_pkg::DRV_HIZ: begin
          pad_o.hi_drv = 1'b0;
        end
        port_pkg::DRV_PCH: begin
          pad_o.hi_drv = drive_data;
        end
        port_pkg::DRV_NCH: begin
          pad_o.lo_drv = ~drive_data;
        end
        port_pkg::DRV_CMOS: begin
          pad_o.hi_drv = drive_data;
          pad_o.lo_drv = ~drive_data;
        end
        default: begin
          pad_o.hi_drv = 1'b0;
        end
      endcase
    end else begin
      case (cfg_i.drive)
        port_pkg::IN_PULL_DOWN: begin
          pad_o.pd_en = 1'b1;
        end
        port_pkg::IN_PULL_UP: begin
          pad_o.pu_en = 1'b1;
        end
        default: begin
          pad_o.pu_en = 1'b0;
        end
      endcase
    end
    pad_o.oe_n  = ~(pad_o.hi_drv | pad_o.lo_drv);
    pad_o.level = pad_o.hi_drv;
  end

endmodule // pin_pad_decode
`default_nettype wire

/* logic/port_pad_mode_control.sv */
// Notes on behaviour
// - Output mode, code 00: driver off; this is the reset state.
// - Output mode, code 01: drive high on data 1, release on data 0.
// - Output mode, code 10: drive low on data 0, release on data 1.
// - Output mode, code 11: push-pull drive following the data bit.
// - Input mode, code 00 or 11: no pulls, driver off.
// - Input mode, code 01: pull-down on, pull-up off, driver off.
// - Input mode, code 10: pull-up on, pull-down off, driver off.
// - Direction 0 decodes the output table, direction 1 the input table.
// - Pin n code bit 0 lives in low config bit n, bit 1 in high.
// - Low config and low function registers take 8 and 16-bit access, reset 00.
// - High config register is read/write, byte access only, resets to 00.
// - High function register is byte access only, resets to zero.
// - Pin n function code is high and low function bit n.
// - Function code 00 selects general-purpose I/O; reset selection.
// - Prohibited function in output mode ignores data: hi-z or held low.
// - Output mode drives the data bit under function 00, the alternate output under other functions; input mode reads return pin levels.
`timescale 1ns/10ps
`default_nettype none
module port_pad_mode_control (
  input  wire logic                              CLK_I,
  input  wire logic                              NRST_I,
  input  wire logic [port_pkg::AXI_ADDR_W-1:0]   S_AXI_AWADDR_I,
  input  wire logic                              S_AXI_AWVALID_I,
  output logic                                   S_AXI_AWREADY_O,
  input  wire logic [31:0]                       S_AXI_WDATA_I,
  input  wire logic [3:0]                        S_AXI_WSTRB_I,
  input  wire logic                              S_AXI_WVALID_I,
  output logic                                   S_AXI_WREADY_O,
  output logic [1:0]                             S_AXI_BRESP_O,
  output logic                                   S_AXI_BVALID_O,
  input  wire logic                              S_AXI_BREADY_I,
  input  wire logic [port_pkg::AXI_ADDR_W-1:0]   S_AXI_ARADDR_I,
  input  wire logic                              S_AXI_ARVALID_I,
  output logic                                   S_AXI_ARREADY_O,
  output logic [31:0]                            S_AXI_RDATA_O,
  output logic [1:0]                             S_AXI_RRESP_O,
  output logic                                   S_AXI_RVALID_O,
  input  wire logic                              S_AXI_RREADY_I,
  input  wire logic [port_pkg::PIN_N-1:0]        PAD_IN_I,
  input  wire logic [port_pkg::PIN_N-1:0]        ALT_OUT_I,
  output port_pkg::pad_bit_s [port_pkg::PIN_N-1:0] PAD_O,
  output logic [port_pkg::PIN_N-1:0][1:0]        FUNC_CODE_O,
  output logic [port_pkg::PIN_N-1:0]             PIN_LEVEL_O
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]                      pin_data_reg;
    logic [7:0]                      pin_direction_reg;
    logic [7:0]                      pin_drive_config_lo;
    logic [7:0]                      pin_drive_config_hi;
    logic [7:0]                      pin_function_select_lo;
    logic [7:0]                      pin_function_select_hi;
    logic                            aw_held;
    logic [port_pkg::AXI_ADDR_W-1:0] aw_addr;
    logic                            w_held;
    logic [15:0]                     w_data;
    logic [1:0]                      w_strb;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            rvalid;
    logic [31:0]                     rdata;
    logic [1:0]                      rresp;
  } ctrl_s;

  ctrl_s                         state_reg;
  ctrl_s                         state_next;
  logic                          rst_n;
  logic [port_pkg::PIN_N-1:0]    pin_level;
  logic [port_pkg::PIN_N-1:0]    data_view;
  logic [15:0]                   w_idx;
  logic [15:0]                   r_idx;
  logic                          aw_take;
  logic                          w_take;
  logic                          ar_take;
  logic                          w_hit;
  port_pkg::pin_cfg_s [port_pkg::PIN_N-1:0] pin_cfg;

  // ****************************************************************
  // Reset release and pin sampling
  // ****************************************************************
  // Reset is applied at once but released only in step with the clock.
  level_sync #(
    .W       (1)
  ) u_reset_sync (
    .clk_i   (CLK_I),
    .rst_n_i (NRST_I),
    .d_i     (1'b1),
    .q_o     (rst_n)
  );

  // Pad levels come from outside the clock domain.
  level_sync #(
    .W       (port_pkg::PIN_N)
  ) u_pad_sync (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .d_i     (PAD_IN_I),
    .q_o     (pin_level)
  );

  // Input-mode pins read their sampled level, output-mode pins the stored bit.
  assign data_view = (state_reg.pin_direction_reg & pin_level) |
                     (~state_reg.pin_direction_reg & state_reg.pin_data_reg);

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  function automatic logic [34:0] read_word(input logic [15:0] idx, input ctrl_s s, input logic [7:0] pins);
    logic [34:0] r;
    r = {port_pkg::RESP_OKAY, 1'b1, 32'h00000000};
    case (idx)
      port_pkg::IDX_PIN_DATA: begin
        r[7:0] = pins;
      end
      port_pkg::IDX_PIN_DIR: begin
        r[7:0] = s.pin_direction_reg;
      end
      port_pkg::IDX_DRIVE_LO: begin
        r[15:0] = {s.pin_drive_config_hi, s.pin_drive_config_lo};
      end
      port_pkg::IDX_DRIVE_HI: begin
        r[7:0] = s.pin_drive_config_hi;
      end
      port_pkg::IDX_FUNC_LO: begin
        r[15:0] = {s.pin_function_select_hi, s.pin_function_select_lo};
      end
      port_pkg::IDX_FUNC_HI: begin
        r[7:0] = s.pin_function_select_hi;
      end
      default: begin
        r = {port_pkg::RESP_SLVERR, 1'b0, 32'h00000000};
      end
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  // Address and data are captured separately so the master may offer them in either order.
  assign S_AXI_AWREADY_O = ~state_reg.aw_held;
  assign S_AXI_WREADY_O  = ~state_reg.w_held;
  assign S_AXI_ARREADY_O = ~state_reg.rvalid;
  assign aw_take         = S_AXI_AWVALID_I & ~state_reg.aw_held;
  assign w_take          = S_AXI_WVALID_I & ~state_reg.w_held;
  assign ar_take         = S_AXI_ARVALID_I & ~state_reg.rvalid;
  assign w_idx           = state_reg.aw_addr[port_pkg::IDX_LSB +: 16];
  assign r_idx           = S_AXI_ARADDR_I[port_pkg::IDX_LSB +: 16];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [34:0] rd;
    state_next = state_reg;
    w_hit      = 1'b1;
    rd         = read_word(r_idx, state_reg, data_view);
    if (aw_take) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = S_AXI_AWADDR_I;
    end
    if (w_take) begin
      state_next.w_held = 1'b1;
      state_next.w_data = S_AXI_WDATA_I[15:0];
      state_next.w_strb = S_AXI_WSTRB_I[1:0];
    end
    if (state_reg.bvalid & S_AXI_BREADY_I) begin
      state_next.bvalid = 1'b0;
    end
    // A write is committed only once the previous response has been accepted.
    if (state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid) begin
      case (w_idx)
        port_pkg::IDX_PIN_DATA: begin
          if (state_reg.w_strb[0]) begin
            state_next.pin_data_reg = state_reg.w_data[7:0];
          end
        end
        port_pkg::IDX_PIN_DIR: begin
          if (state_reg.w_strb[0]) begin
            state_next.pin_direction_reg = state_reg.w_data[7:0];
          end
        end
        port_pkg::IDX_DRIVE_LO: begin
          if (state_reg.w_strb[0]) begin
            state_next.pin_drive_config_lo = state_reg.w_data[7:0];
          end
          if (state_reg.w_strb[1]) begin
            state_next.pin_drive_config_hi = state_reg.w_data[15:8];
          end
        end
        port_pkg::IDX_DRIVE_HI: begin
          // Only the low lane reaches a byte-only register.
          if (state_reg.w_strb[0]) begin
            state_next.pin_drive_config_hi = state_reg.w_data[7:0];
          end
        end
        port_pkg::IDX_FUNC_LO: begin
          if (state_reg.w_strb[0]) begin
            state_next.pin_function_select_lo = state_reg.w_data[7:0] & port_pkg::FUNC_WR_MASK;
          end
          if (state_reg.w_strb[1]) begin
            state_next.pin_function_select_hi = state_reg.w_data[15:8] & port_pkg::FUNC_WR_MASK;
          end
        end
        port_pkg::IDX_FUNC_HI: begin
          if (state_reg.w_strb[0]) begin
            state_next.pin_function_select_hi = state_reg.w_data[7:0] & port_pkg::FUNC_WR_MASK;
          end
        end
        default: begin
          w_hit = 1'b0;
        end
      endcase
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = w_hit ? port_pkg::RESP_OKAY : port_pkg::RESP_SLVERR;
    end
    if (state_reg.rvalid & S_AXI_RREADY_I) begin
      state_next.rvalid = 1'b0;
    end
    // The read word is captured at the address handshake and held until taken.
    if (ar_take) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd[31:0];
      state_next.rresp  = rd[34:33];
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                        <= '0;
      state_reg.pin_data_reg           <= port_pkg::RST_BYTE;
      state_reg.pin_direction_reg      <= port_pkg::RST_BYTE;
      state_reg.pin_drive_config_lo    <= port_pkg::RST_BYTE;
      state_reg.pin_drive_config_hi    <= port_pkg::RST_BYTE;
      state_reg.pin_function_select_lo <= port_pkg::RST_BYTE;
      state_reg.pin_function_select_hi <= port_pkg::RST_BYTE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign S_AXI_BVALID_O = state_reg.bvalid;
  assign S_AXI_BRESP_O  = state_reg.bresp;
  assign S_AXI_RVALID_O = state_reg.rvalid;
  assign S_AXI_RDATA_O  = state_reg.rdata;
  assign S_AXI_RRESP_O  = state_reg.rresp;
  assign PIN_LEVEL_O    = pin_level;

  // ****************************************************************
  // Per-pin pad decode
  // ****************************************************************
  // Pad controls follow the registers combinationally, so a mode change reaches the pin on the same edge that commits the write.
  for (genvar n = 0; n < port_pkg::PIN_N; n++) begin : g_pin
    always_comb begin
      pin_cfg[n].dir    = state_reg.pin_direction_reg[n];
      pin_cfg[n].drive  = {state_reg.pin_drive_config_hi[n], state_reg.pin_drive_config_lo[n]};
      pin_cfg[n].func   = {state_reg.pin_function_select_hi[n], state_reg.pin_function_select_lo[n]};
      pin_cfg[n].banned = port_pkg::FUNC_BANNED[n*4 +: 4];
      pin_cfg[n].data   = state_reg.pin_data_reg[n];
      pin_cfg[n].alt    = ALT_OUT_I[n];
    end
    assign FUNC_CODE_O[n] = pin_cfg[n].func;
    pin_pad_decode u_decode (
      .cfg_i (pin_cfg[n]),
      .pad_o (PAD_O[n])
    );
  end

endmodule // port_pad_mode_control
`default_nettype wire

/* shared/port_pkg.sv */
`default_nettype none
package port_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int PIN_N      = 8;
  localparam int AXI_ADDR_W = 18;

  // ****************************************************************
  // Register indices; the byte address is four times the index
  // ****************************************************************
  localparam logic [15:0] IDX_PIN_DATA     = 16'hf278;
  localparam logic [15:0] IDX_PIN_DIR      = 16'hf279;
  localparam logic [15:0] IDX_DRIVE_LO     = 16'hf27a;
  localparam logic [15:0] IDX_DRIVE_HI     = 16'hf27b;
  localparam logic [15:0] IDX_FUNC_LO      = 16'hf27c;
  localparam logic [15:0] IDX_FUNC_HI      = 16'hf27d;
  localparam int          IDX_LSB          = 2;

  // ****************************************************************
  // Reset values and field layouts
  // ****************************************************************
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [7:0]  FUNC_WR_MASK     = 8'h0f;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic        DIR_OUT          = 1'b0;
  localparam logic        DIR_IN           = 1'b1;
  localparam logic [1:0]  DRV_HIZ          = 2'h0;
  localparam logic [1:0]  DRV_PCH          = 2'h1;
  localparam logic [1:0]  DRV_NCH          = 2'h2;
  localparam logic [1:0]  DRV_CMOS         = 2'h3;
  localparam logic [1:0]  IN_PULL_DOWN     = 2'h1;
  localparam logic [1:0]  IN_PULL_UP       = 2'h2;
  localparam logic [1:0]  FUNC_GPIO        = 2'h0;

  // One nibble per pin, pin 0 lowest; bit c set means function code c is prohibited.
  localparam logic [PIN_N*4-1:0] FUNC_BANNED = 32'h422208aa;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       dir;
    logic [1:0] drive;
    logic [1:0] func;
    logic [3:0] banned;
    logic       data;
    logic       alt;
  } pin_cfg_s;

  typedef struct packed {
    logic oe_n;
    logic hi_drv;
    logic lo_drv;
    logic pu_en;
    logic pd_en;
    logic level;
  } pad_bit_s;

endpackage
`default_nettype wire

/* verif/pad_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pad_model (
  input wire logic                                  clk_i,
  input wire port_pkg::pad_bit_s [port_pkg::PIN_N-1:0] pad_i,
  output logic [port_pkg::PIN_N-1:0]                level_o
);
  // ****************************************************************
  // Pin wire levels
  // ****************************************************************
  // A pin nobody drives or pulls toggles each cycle, so a floating read is never mistaken for a value.
  logic [7:0] float_reg = 8'h55;
  always_ff @(posedge clk_i) float_reg <= ~float_reg;
  always_comb begin
    for (int k = 0; k < port_pkg::PIN_N; k++) begin
      if (!pad_i[k].oe_n) level_o[k] = pad_i[k].level;
      else if (pad_i[k].pu_en) level_o[k] = 1'b1;
      else if (pad_i[k].pd_en) level_o[k] = 1'b0;
      else level_o[k] = float_reg[k];
    end
  end
endmodule // pad_model
`default_nettype wire

/* verif/port_pad_mode_control_props.sv */
`timescale 1ns/10ps
`default_nettype none
module port_pad_mode_control_props (
  input wire logic                                  CLK_I,
  input wire logic                                  NRST_I,
  input wire logic                                  S_AXI_AWVALID_I,
  input wire logic                                  S_AXI_AWREADY_O,
  input wire logic                                  S_AXI_WVALID_I,
  input wire logic                                  S_AXI_WREADY_O,
  input wire logic [1:0]                            S_AXI_BRESP_O,
  input wire logic                                  S_AXI_BVALID_O,
  input wire logic                                  S_AXI_BREADY_I,
  input wire logic                                  S_AXI_ARVALID_I,
  input wire logic                                  S_AXI_ARREADY_O,
  input wire logic [31:0]                           S_AXI_RDATA_O,
  input wire logic                                  S_AXI_RVALID_O,
  input wire logic                                  S_AXI_RREADY_I,
  input wire port_pkg::pad_bit_s [port_pkg::PIN_N-1:0] PAD_O,
  input wire logic [port_pkg::PIN_N-1:0][1:0]       FUNC_CODE_O
);
  // ****************************************************************
  // Per-pin views of the pad controls
  // ****************************************************************
  logic [7:0] pu, pd, hi, lo, oen, lvl;
  always_comb begin
    for (int k = 0; k < port_pkg::PIN_N; k++) begin
      pu[k] = PAD_O[k].pu_en;
      pd[k] = PAD_O[k].pd_en;
      hi[k] = PAD_O[k].hi_drv;
      lo[k] = PAD_O[k].lo_drv;
      oen[k] = PAD_O[k].oe_n;
      lvl[k] = PAD_O[k].level;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_ar_take; S_AXI_ARVALID_I && S_AXI_ARREADY_O; endsequence
  sequence s_wr_take; S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O; endsequence
  property p_pull_excl; (pu & pd) == 8'h00; endproperty
  property p_pull_nodrv; ((pu | pd) & ~oen) == 8'h00; endproperty
  property p_oe_match; oen == ~(hi | lo); endproperty
  property p_hilo_excl; (hi & lo) == 8'h00; endproperty
  property p_level; lvl == hi; endproperty
  property p_func_ro; FUNC_CODE_O[7:4] == 8'h00; endproperty
  property p_rd_lat; s_ar_take |=> S_AXI_RVALID_O; endproperty
  property p_r_hold; S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O); endproperty
  property p_ar_block; S_AXI_RVALID_O |-> !S_AXI_ARREADY_O; endproperty
  property p_wr_lat; s_wr_take ##0 !S_AXI_BVALID_O |-> ##[1:2] S_AXI_BVALID_O; endproperty
  property p_b_hold; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O); endproperty
  a_pull_excl:
    assert property (p_pull_excl) else $error("pull-up and pull-down both on");
  a_pull_nodrv:
    assert property (p_pull_nodrv) else $error("driver on while pulled");
  a_oe_match:
    assert property (p_oe_match) else $error("enable does not match drives");
  a_hilo_excl:
    assert property (p_hilo_excl) else $error("high and low drive together");
  a_level:
    assert property (p_level) else $error("level differs from high drive");
  a_func_ro:
    assert property (p_func_ro) else $error("upper function code not zero");
  a_rd_lat:
    assert property (p_rd_lat) else $error("read answer late");
  a_r_hold:
    assert property (p_r_hold) else $error("read data moved before taken");
  a_ar_block:
    assert property (p_ar_block) else $error("second read taken early");
  a_wr_lat:
    assert property (p_wr_lat) else $error("write answer late");
  a_b_hold:
    assert property (p_b_hold) else $error("write response moved before taken");
endmodule // port_pad_mode_control_props
bind port_pad_mode_control port_pad_mode_control_props u_props (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I), .PAD_O(PAD_O), .FUNC_CODE_O(FUNC_CODE_O)
);
`default_nettype wire

/* verif/port_pad_mode_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module port_pad_mode_control_test;
  // ****************************************************************
  // Bench signals and tasks
  // ****************************************************************
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, c;
  logic [7:0] pad_in, alt, pin_lvl, lo_b, hi_b, msk;
  logic [7:0][1:0] fcode;
  port_pkg::pad_bit_s [7:0] pad;
  int errors = 0;
  int compares = 0;
  localparam logic [1:0] OK = port_pkg::RESP_OKAY;

  port_pad_mode_control DUT (
    .CLK_I(clk), .NRST_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .PAD_IN_I(pad_in), .ALT_OUT_I(alt), .PAD_O(pad),
    .FUNC_CODE_O(fcode), .PIN_LEVEL_O(pin_lvl));
  pad_model u_pins (.clk_i(clk), .pad_i(pad), .level_o(pad_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pad(input port_pkg::pad_bit_s got, input port_pkg::pad_bit_s exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready is combinational of state, so its value at the falling edge is what the next rising edge samples.
  task automatic axi_write(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
    logic a_t, w_t, b_t;
    logic [1:0] r;
    int n;
    b_t = 1'b0;
    n = 0;
    r = 2'h0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge clk);
      a_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge clk);
      if (a_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
      n++;
      if (n > 40) begin
        errors++;
        wrap_up();
      end
    end
    chk_word({30'h0, r}, {30'h0, er});
  endtask

  task automatic axi_read(input logic [15:0] idx, output logic [31:0] q, input logic [1:0] er);
    logic a_t, r_t;
    logic [1:0] r;
    int n;
    r_t = 1'b0;
    n = 0;
    r = 2'h0;
    q = 32'h0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge clk);
      a_t = arvalid && arready;
      r_t = rvalid;
      q = rdata;
      r = rresp;
      @(posedge clk);
      if (a_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
      n++;
      if (n > 40) begin
        errors++;
        wrap_up();
      end
    end
    chk_word({30'h0, r}, {30'h0, er});
  endtask

  // Expected pad controls for one pin, worked out from the drive and pull tables.
  function automatic port_pkg::pad_bit_s exp_pad(input logic dir, input logic [1:0] cd, input logic d);
    port_pkg::pad_bit_s p;
    p = '0;
    if (dir == port_pkg::DIR_OUT) begin
      p.hi_drv = d && cd[0];
      p.lo_drv = !d && cd[1];
    end else begin
      p.pd_en = (cd == 2'h1);
      p.pu_en = (cd == 2'h2);
    end
    p.oe_n = !(p.hi_drv || p.lo_drv);
    p.level = p.hi_drv;
    return p;
  endfunction

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 18'h0;
    araddr = 18'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    alt = 8'h00;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      axi_read(port_pkg::IDX_DRIVE_LO + 16'(i), rd, OK);
      chk_word(rd, 32'h0);
    end
    for (int n = 0; n < 8; n++) chk_pad(pad[n], exp_pad(1'b0, 2'h0, 1'b0));
    chk_word({16'h0, fcode}, 32'h0);
    $display("test reset done, errors %0d", errors);

    axi_write(port_pkg::IDX_DRIVE_LO, 16'ha55a, 4'h3, OK);
    axi_read(port_pkg::IDX_DRIVE_LO, rd, OK);
    chk_word(rd, 32'h0000a55a);
    axi_read(port_pkg::IDX_DRIVE_HI, rd, OK);
    chk_word(rd, 32'h000000a5);
    axi_write(port_pkg::IDX_DRIVE_HI, 16'hff3c, 4'h1, OK);
    axi_read(port_pkg::IDX_DRIVE_LO, rd, OK);
    chk_word(rd, 32'h00003c5a);
    axi_write(port_pkg::IDX_FUNC_LO, 16'hffff, 4'h3, OK);
    axi_read(port_pkg::IDX_FUNC_LO, rd, OK);
    chk_word(rd, 32'h00000f0f);
    chk_word({16'h0, fcode}, 32'h000000ff);
    axi_write(port_pkg::IDX_FUNC_LO, 16'h0000, 4'h3, OK);
    axi_write(16'h1234, 16'h00ff, 4'h1, port_pkg::RESP_SLVERR);
    axi_read(16'h1234, rd, port_pkg::RESP_SLVERR);
    chk_word(rd, 32'h0);
    $display("test registers done, errors %0d", errors);

    for (int k = 0; k < 4; k++) for (int dv = 0; dv < 2; dv++) for (int d = 0; d < 2; d++) begin
      for (int n = 0; n < 8; n++) begin
        c = 2'(n + k);
        lo_b[n] = c[0];
        hi_b[n] = c[1];
      end
      axi_write(port_pkg::IDX_PIN_DIR, {8'h00, {8{dv[0]}}}, 4'h1, OK);
      axi_write(port_pkg::IDX_DRIVE_LO, {hi_b, lo_b}, 4'h3, OK);
      axi_write(port_pkg::IDX_PIN_DATA, {8'h00, {8{d[0]}}}, 4'h1, OK);
      repeat (3) @(posedge clk);
      for (int n = 0; n < 8; n++) chk_pad(pad[n], exp_pad(dv[0], 2'(n + k), d[0]));
      axi_read(port_pkg::IDX_PIN_DATA, rd, OK);
      msk = dv[0] ? (lo_b ^ hi_b) : 8'hff;
      chk_word(rd & {24'h0, msk}, {24'h0, msk & (dv[0] ? hi_b : {8{d[0]}})});
    end
    $display("test decode done, errors %0d", errors);

    axi_write(port_pkg::IDX_PIN_DIR, 16'h0000, 4'h1, OK);
    axi_write(port_pkg::IDX_PIN_DATA, 16'h00ff, 4'h1, OK);
    axi_write(port_pkg::IDX_FUNC_LO, 16'h0009, 4'h3, OK);
    chk_word({16'h0, fcode}, 32'h00000041);
    for (int m = 0; m < 4; m++) begin
      c = 2'(m);
      axi_write(port_pkg::IDX_DRIVE_LO, {{8{c[1]}}, {8{c[0]}}}, 4'h3, OK);
      repeat (2) @(posedge clk);
      chk_pad(pad[0], exp_pad(1'b0, c, 1'b0));
      chk_pad(pad[3], exp_pad(1'b0, c, alt[3]));
      chk_pad(pad[1], exp_pad(1'b0, c, 1'b1));
    end
    $display("test functions done, errors %0d", errors);
    wrap_up();
  end
endmodule // port_pad_mode_control_test
`default_nettype wire
